// ==== design/acl_match_pkg.sv ====
package acl_match_pkg;

   // register byte offsets on the plain register port
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_SRC_ADDR = 8'h04;
   localparam logic [7:0] OFS_SRC_MASK = 8'h08;
   localparam logic [7:0] OFS_DST_ADDR = 8'h0c;
   localparam logic [7:0] OFS_DST_MASK = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam logic [7:0] OFS_HIT_CNT  = 8'h18;

   // control register field positions
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_FT_LSB    = 1;
   localparam int CTRL_PROTO_LSB = 3;
   localparam int CTRL_TTL_LSB   = 6;
   localparam int CTRL_FRAG_LSB  = 8;
   localparam int CTRL_OPT_LSB   = 10;
   localparam int CTRL_SRC_LSB   = 12;
   localparam int CTRL_DST_LSB   = 14;
   localparam int CTRL_PVAL_LSB  = 16;

   // status register field positions
   localparam int STAT_HIT_BIT   = 0;
   localparam int STAT_IPV4_BIT  = 1;
   localparam int STAT_ICMP_BIT  = 2;
   localparam int STAT_UDP_BIT   = 3;
   localparam int STAT_TCP_BIT   = 4;

   // reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'hffff_ffff;
   localparam logic [31:0] CNT_RESET  = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

   // header constants
   localparam logic [7:0] IP_PROTO_ICMP  = 8'h01;
   localparam logic [7:0] IP_PROTO_TCP   = 8'h06;
   localparam logic [7:0] IP_PROTO_UDP   = 8'h11;
   localparam logic [3:0] IHL_NO_OPTIONS = 4'h5;
   localparam logic [7:0] TTL_ZERO       = 8'h00;
   localparam logic [12:0] FRAG_OFF_ZERO = 13'h0000;
   localparam logic [31:0] CNT_ONE       = 32'h0000_0001;

   // frame type selection of the entry
   typedef enum logic [1:0] {
      FT_ANY  = 2'b00,
      FT_IPV4 = 2'b01
   } frame_type_t;

   // protocol condition
   typedef enum logic [2:0] {
      PROTO_ANY      = 3'b000,
      PROTO_SPECIFIC = 3'b001,
      PROTO_ICMP     = 3'b010,
      PROTO_UDP      = 3'b011,
      PROTO_TCP      = 3'b100
   } proto_mode_t;

   // three-way condition for ttl, fragment and option
   typedef enum logic [1:0] {
      COND_ANY = 2'b00,
      COND_NO  = 2'b01,
      COND_YES = 2'b10
   } cond3_t;

   // address condition
   typedef enum logic [1:0] {
      ADDR_ANY     = 2'b00,
      ADDR_HOST    = 2'b01,
      ADDR_NETWORK = 2'b10
   } addr_mode_t;

endpackage

// ==== design/acl_addr_cond.sv ====
`timescale 1ns/1ps
// one address condition, used for source and for destination
module acl_addr_cond (
   // configuration
   input  wire acl_match_pkg::addr_mode_t mode_in,
   input  wire logic [31:0]               cfg_addr_in,
   input  wire logic [31:0]               cfg_mask_in,
   // frame
   input  wire logic [31:0]               frame_addr_in,
   // result
   output logic                           ok_out
);

   // combinational decision, registered by the parent
   always_comb begin
      unique case (mode_in)
         acl_match_pkg::ADDR_ANY: begin
            ok_out = 1'b1;
         end
         acl_match_pkg::ADDR_HOST: begin
            ok_out = (frame_addr_in == cfg_addr_in);
         end
         acl_match_pkg::ADDR_NETWORK: begin
            // zero mask bits drop out on both sides
            ok_out = ((frame_addr_in & cfg_mask_in) == (cfg_addr_in & cfg_mask_in));
         end
         default: begin
            // unused code never hits, safer than matching all
            ok_out = 1'b0;
         end
      endcase
   end

endmodule // acl_addr_cond

// ==== design/ipv4_acl_entry_matcher.sv ====
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Contract
// - ipv4 conditions apply only for ipv4 frame type
// - protocol any accepts every protocol value
// - specific protocol hits only equal 8-bit value
// - icmp/udp/tcp restrict protocol, enable extra fields
// - ttl zero refuses ttl above zero
// - ttl non-zero lets ttl above zero hit
// - any leaves ttl, fragment, option out
// - fragment no refuses fragmented frames
// - fragment yes lets fragmented frames hit
// - option no refuses frames with options
// - option yes lets frames with options hit
// - source any ignores source address
// - source host needs exact source match
// - source network compares under source mask
// - zero mask bit makes address bit don't-care
// - destination any ignores destination address
// - destination host needs exact destination match
// - destination network compares under destination mask
module ipv4_acl_entry_matcher (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wr_data_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rd_data_out,
   // parsed header from the ingress parser
   input  wire logic        frame_valid_in,
   input  wire logic        frame_is_ipv4_in,
   input  wire logic [7:0]  frame_proto_in,
   input  wire logic [7:0]  frame_ttl_in,
   input  wire logic        frame_more_frag_in,
   input  wire logic [12:0] frame_frag_off_in,
   input  wire logic [3:0]  frame_ihl_in,
   input  wire logic [31:0] frame_src_addr_in,
   input  wire logic [31:0] frame_dst_addr_in,
   // match result
   output logic             match_valid_out,
   output logic             match_hit_out,
   // extra condition field enables
   output logic             icmp_fields_en_out,
   output logic             udp_fields_en_out,
   output logic             tcp_fields_en_out
);

   // three-way check shared by ttl, fragment and option
   // code 2'b11 is unused and refuses, never matches all
   function automatic logic cond3_ok(input acl_match_pkg::cond3_t mode, input logic present);
      logic ok;
      ok = 1'b0;
      unique case (mode)
         acl_match_pkg::COND_ANY: ok = 1'b1;
         acl_match_pkg::COND_NO:  ok = !present;
         acl_match_pkg::COND_YES: ok = present;
         default:                 ok = 1'b0;
      endcase
      return ok;
   endfunction

   // configuration state
   // written only by software, never by the frame path
   logic [31:0] ctrl_q;      // mode fields and protocol value
   logic [31:0] ctrl_d;
   logic [31:0] src_addr_q;  // source address condition value
   logic [31:0] src_addr_d;
   logic [31:0] src_mask_q;  // source mask
   logic [31:0] src_mask_d;
   logic [31:0] dst_addr_q;  // destination address condition value
   logic [31:0] dst_addr_d;
   logic [31:0] dst_mask_q;  // destination mask
   logic [31:0] dst_mask_d;

   // result state
   // hit and valid move together so the counter sees both
   logic        hit_q;       // last decision
   logic        hit_d;
   logic        valid_q;     // one-cycle decision strobe
   logic        valid_d;
   logic [31:0] hit_cnt_q;   // hits since last clear
   logic [31:0] hit_cnt_d;
   logic [2:0]  l4_en_q;     // icmp, udp, tcp field enables
   logic [2:0]  l4_en_d;
   logic [31:0] rd_data_q;   // read data, one cycle after strobe
   logic [31:0] rd_data_d;

   // decoded fields of the control register
   // plain slices of ctrl_q, no decode delay
   logic                        entry_en;
   acl_match_pkg::frame_type_t  frame_type;
   acl_match_pkg::proto_mode_t  proto_mode;
   acl_match_pkg::cond3_t       ttl_mode;
   acl_match_pkg::cond3_t       frag_mode;
   acl_match_pkg::cond3_t       opt_mode;
   acl_match_pkg::addr_mode_t   src_mode;
   acl_match_pkg::addr_mode_t   dst_mode;
   logic [7:0]                  proto_value;

   // per-condition results
   // each one a pure function of the header now offered
   logic        proto_ok;    // protocol condition
   logic        ttl_ok;      // ttl condition
   logic        frag_ok;     // fragment condition
   logic        opt_ok;      // option condition
   logic        src_ok;      // source address condition
   logic        dst_ok;      // destination address condition
   logic        ipv4_ok;     // all ipv4 header conditions

   // field extraction
   // casts keep the enum types; unused codes reach the defaults
   assign entry_en    = ctrl_q[acl_match_pkg::CTRL_EN_BIT];
   assign frame_type  = acl_match_pkg::frame_type_t'(ctrl_q[acl_match_pkg::CTRL_FT_LSB +: 2]);
   assign proto_mode  = acl_match_pkg::proto_mode_t'(ctrl_q[acl_match_pkg::CTRL_PROTO_LSB +: 3]);
   assign ttl_mode    = acl_match_pkg::cond3_t'(ctrl_q[acl_match_pkg::CTRL_TTL_LSB +: 2]);
   assign frag_mode   = acl_match_pkg::cond3_t'(ctrl_q[acl_match_pkg::CTRL_FRAG_LSB +: 2]);
   assign opt_mode    = acl_match_pkg::cond3_t'(ctrl_q[acl_match_pkg::CTRL_OPT_LSB +: 2]);
   assign src_mode    = acl_match_pkg::addr_mode_t'(ctrl_q[acl_match_pkg::CTRL_SRC_LSB +: 2]);
   assign dst_mode    = acl_match_pkg::addr_mode_t'(ctrl_q[acl_match_pkg::CTRL_DST_LSB +: 2]);
   assign proto_value = ctrl_q[acl_match_pkg::CTRL_PVAL_LSB +: 8];

   // source address condition
   // one module for both sides keeps the two compares alike
   acl_addr_cond u_src_cond (
      .mode_in       (src_mode),
      .cfg_addr_in   (src_addr_q),
      .cfg_mask_in   (src_mask_q),
      .frame_addr_in (frame_src_addr_in),
      .ok_out        (src_ok)
   );

   // destination address condition
   acl_addr_cond u_dst_cond (
      .mode_in       (dst_mode),
      .cfg_addr_in   (dst_addr_q),
      .cfg_mask_in   (dst_mask_q),
      .frame_addr_in (frame_dst_addr_in),
      .ok_out        (dst_ok)
   );

   // protocol condition
   // specific value and fixed numbers each take their own 8-bit compare
   always_comb begin
      unique case (proto_mode)
         acl_match_pkg::PROTO_ANY: begin
            proto_ok = 1'b1;
         end
         acl_match_pkg::PROTO_SPECIFIC: begin
            proto_ok = (frame_proto_in == proto_value);
         end
         acl_match_pkg::PROTO_ICMP: begin
            proto_ok = (frame_proto_in == acl_match_pkg::IP_PROTO_ICMP);
         end
         acl_match_pkg::PROTO_UDP: begin
            proto_ok = (frame_proto_in == acl_match_pkg::IP_PROTO_UDP);
         end
         acl_match_pkg::PROTO_TCP: begin
            proto_ok = (frame_proto_in == acl_match_pkg::IP_PROTO_TCP);
         end
         default: begin
            // unused codes 5..7 never hit
            proto_ok = 1'b0;
         end
      endcase
   end

   // ttl, fragment and option conditions
   // present flags are worked out once, modes only pick
   always_comb begin
      ttl_ok  = cond3_ok(ttl_mode, frame_ttl_in != acl_match_pkg::TTL_ZERO);
      frag_ok = cond3_ok(frag_mode, frame_more_frag_in ||
                         (frame_frag_off_in != acl_match_pkg::FRAG_OFF_ZERO));
      // header longer than five words carries options
      opt_ok  = cond3_ok(opt_mode, frame_ihl_in > acl_match_pkg::IHL_NO_OPTIONS);
      ipv4_ok = proto_ok && ttl_ok && frag_ok && opt_ok && src_ok && dst_ok;
   end

   // configuration writes
   // a write lands at its strobe edge, seen by the next frame
   always_comb begin
      ctrl_d     = ctrl_q;
      src_addr_d = src_addr_q;
      src_mask_d = src_mask_q;
      dst_addr_d = dst_addr_q;
      dst_mask_d = dst_mask_q;
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            acl_match_pkg::OFS_CTRL:     ctrl_d     = reg_wr_data_in;
            acl_match_pkg::OFS_SRC_ADDR: src_addr_d = reg_wr_data_in;
            acl_match_pkg::OFS_SRC_MASK: src_mask_d = reg_wr_data_in;
            acl_match_pkg::OFS_DST_ADDR: dst_addr_d = reg_wr_data_in;
            acl_match_pkg::OFS_DST_MASK: dst_mask_d = reg_wr_data_in;
            // read-only and unmapped writes are dropped
            default: begin
            end
         endcase
      end
   end

   // match decision, one cycle after the header
   // a disabled entry still answers, with hit low
   always_comb begin
      valid_d = frame_valid_in;
      hit_d   = 1'b0;
      if (frame_valid_in && entry_en) begin
         if (frame_type == acl_match_pkg::FT_IPV4) begin
            // non-ipv4 frames cannot hit an ipv4 entry
            hit_d = frame_is_ipv4_in && ipv4_ok;
         end else if (frame_type == acl_match_pkg::FT_ANY) begin
            // header conditions take no part here
            // the enable alone decides
            hit_d = 1'b1;
         end else begin
            // unused frame type codes never hit
            hit_d = 1'b0;
         end
      end
      // extra fields follow the protocol choice of an ipv4 entry
      // levels, not pulses: they follow ctrl_q, not frame_valid_in
      l4_en_d = 3'b000;
      if (frame_type == acl_match_pkg::FT_IPV4) begin
         l4_en_d[0] = (proto_mode == acl_match_pkg::PROTO_ICMP);
         l4_en_d[1] = (proto_mode == acl_match_pkg::PROTO_UDP);
         l4_en_d[2] = (proto_mode == acl_match_pkg::PROTO_TCP);
      end
   end

   // hit counter: a hit in the clearing cycle is kept
   // wraps at the top; software must clear it in time
   always_comb begin
      hit_cnt_d = hit_cnt_q;
      if (reg_wr_in && (reg_addr_in == acl_match_pkg::OFS_HIT_CNT)) begin
         hit_cnt_d = acl_match_pkg::CNT_RESET;
      end
      if (hit_q && valid_q) begin
         // counts the registered hit, so a clear never loses it
         hit_cnt_d = hit_cnt_d + acl_match_pkg::CNT_ONE;
      end
   end

   // read data mux, unmapped reads return zero
   // zero outside the read slot keeps a shared bus quiet
   always_comb begin
      rd_data_d = acl_match_pkg::READ_ZERO;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            acl_match_pkg::OFS_CTRL:     rd_data_d = ctrl_q;
            acl_match_pkg::OFS_SRC_ADDR: rd_data_d = src_addr_q;
            acl_match_pkg::OFS_SRC_MASK: rd_data_d = src_mask_q;
            acl_match_pkg::OFS_DST_ADDR: rd_data_d = dst_addr_q;
            acl_match_pkg::OFS_DST_MASK: rd_data_d = dst_mask_q;
            acl_match_pkg::OFS_STATUS: begin
               // live view; nothing clears on read
               rd_data_d[acl_match_pkg::STAT_HIT_BIT]  = hit_q;
               rd_data_d[acl_match_pkg::STAT_IPV4_BIT] = (frame_type == acl_match_pkg::FT_IPV4);
               rd_data_d[acl_match_pkg::STAT_ICMP_BIT] = l4_en_q[0];
               rd_data_d[acl_match_pkg::STAT_UDP_BIT]  = l4_en_q[1];
               rd_data_d[acl_match_pkg::STAT_TCP_BIT]  = l4_en_q[2];
            end
            acl_match_pkg::OFS_HIT_CNT:  rd_data_d = hit_cnt_q;
            default: begin
               rd_data_d = acl_match_pkg::READ_ZERO;
            end
         endcase
      end
   end

   // all state registers
   // reset branch loads constants only
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q     <= acl_match_pkg::CTRL_RESET;
         src_addr_q <= acl_match_pkg::ADDR_RESET;
         src_mask_q <= acl_match_pkg::MASK_RESET;
         dst_addr_q <= acl_match_pkg::ADDR_RESET;
         dst_mask_q <= acl_match_pkg::MASK_RESET;
         hit_q      <= 1'b0;
         valid_q    <= 1'b0;
         hit_cnt_q  <= acl_match_pkg::CNT_RESET;
         l4_en_q    <= 3'b000;
         rd_data_q  <= acl_match_pkg::READ_ZERO;
      end else begin
         ctrl_q     <= ctrl_d;
         src_addr_q <= src_addr_d;
         src_mask_q <= src_mask_d;
         dst_addr_q <= dst_addr_d;
         dst_mask_q <= dst_mask_d;
         hit_q      <= hit_d;
         valid_q    <= valid_d;
         hit_cnt_q  <= hit_cnt_d;
         l4_en_q    <= l4_en_d;
         rd_data_q  <= rd_data_d;
      end
   end

   // outputs straight from flops
   // no gates after the flops, so the outputs never glitch
   assign reg_rd_data_out    = rd_data_q;
   assign match_valid_out    = valid_q;
   assign match_hit_out      = hit_q;
   assign icmp_fields_en_out = l4_en_q[0];
   assign udp_fields_en_out  = l4_en_q[1];
   assign tcp_fields_en_out  = l4_en_q[2];

endmodule // ipv4_acl_entry_matcher

// ==== sim/acl_frame_src.sv ====
`timescale 1ns/1ps
// ingress parser stand-in; one header per call, scrambled fields between frames
module acl_frame_src (
   // parsed header toward the entry
   output logic        valid_out,
   output logic        ipv4_out,
   output logic        mf_out,
   output logic [7:0]  proto_out,
   output logic [7:0]  ttl_out,
   output logic [12:0] off_out,
   output logic [3:0]  ihl_out,
   output logic [31:0] src_out,
   output logic [31:0] dst_out
);
   // quiet at time zero
   initial begin
      {valid_out, ipv4_out, mf_out, proto_out, ttl_out, off_out, ihl_out, src_out, dst_out} = '0;
   end
   // offer one header, called right after a rising edge
   task automatic put(input logic v4, mf, input logic [7:0] p, t, input logic [12:0] off,
                      input logic [3:0] ihl, input logic [31:0] sa, da);
      valid_out <= 1'b1;
      {ipv4_out, mf_out, proto_out, ttl_out, off_out, ihl_out, src_out, dst_out} <= {v4, mf, p, t, off, ihl, sa, da};
   endtask
   // no frame: inverted fields, so a stale sample never looks right
   task automatic idle;
      valid_out <= 1'b0;
      {ipv4_out, mf_out, proto_out, ttl_out, off_out, ihl_out, src_out, dst_out} <=
         ~{ipv4_out, mf_out, proto_out, ttl_out, off_out, ihl_out, src_out, dst_out};
   endtask
endmodule // acl_frame_src

// ==== sim/acl_entry_sva.sv ====
`timescale 1ns/1ps
module acl_entry_sva (
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // register port
   input wire logic [7:0]  reg_addr_in,
   input wire logic [31:0] reg_wr_data_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [31:0] reg_rd_data_out,
   // frame path
   input wire logic        frame_valid_in,
   input wire logic        frame_is_ipv4_in,
   input wire logic [7:0]  frame_proto_in,
   input wire logic [7:0]  frame_ttl_in,
   input wire logic        frame_more_frag_in,
   input wire logic [12:0] frame_frag_off_in,
   input wire logic [3:0]  frame_ihl_in,
   input wire logic        match_valid_out,
   input wire logic        match_hit_out,
   input wire logic        icmp_fields_en_out
);
   logic [31:0] ctrl_q; // shadow of the control word, rebuilt from port writes
   logic [31:0] ctrl_d; // next shadow
   // shadow next value
   always_comb begin
      ctrl_d = (reg_wr_in && reg_addr_in == acl_match_pkg::OFS_CTRL) ? reg_wr_data_in : ctrl_q;
   end
   // shadow register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) ctrl_q <= 32'h0000_0000;
      else ctrl_q <= ctrl_d;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // enabled entry, ipv4 type, ipv4 frame offered
   sequence s_v4_frame;
      frame_valid_in && ctrl_q[0] && ctrl_q[2:1] == 2'h1 && frame_is_ipv4_in;
   endsequence
   a_match_latency: assert property (frame_valid_in |=> match_valid_out) else $error("no answer one cycle on");
   a_match_idle: assert property (!frame_valid_in |=> !match_valid_out && !match_hit_out) else $error("answer without frame");
   a_ipv4_gate: assert property (frame_valid_in && ctrl_q[0] && ctrl_q[2:1] == 2'h1 && !frame_is_ipv4_in |=> !match_hit_out)
      else $error("non ipv4 frame hit");
   a_proto_icmp: assert property (s_v4_frame ##0 (ctrl_q[5:3] == 3'h2 && frame_proto_in != 8'h01) |=> !match_hit_out)
      else $error("icmp mode hit other protocol");
   a_ttl_zero: assert property (s_v4_frame ##0 (ctrl_q[7:6] == 2'h1 && frame_ttl_in != 8'h00) |=> !match_hit_out)
      else $error("ttl zero mode hit live frame");
   a_frag_no: assert property (s_v4_frame ##0 (ctrl_q[9:8] == 2'h1 &&
      (frame_more_frag_in || frame_frag_off_in != 13'h0000)) |=> !match_hit_out)
      else $error("fragment no mode hit fragment");
   a_option_no: assert property (s_v4_frame ##0 (ctrl_q[11:10] == 2'h1 && frame_ihl_in > 4'h5) |=> !match_hit_out)
      else $error("option no mode hit options");
   a_off_no_hit: assert property (frame_valid_in && !ctrl_q[0] |=> !match_hit_out) else $error("disabled entry hit");
   a_icmp_fields: assert property (reg_wr_in && reg_addr_in == acl_match_pkg::OFS_CTRL |=> ##1
      icmp_fields_en_out == ($past(ctrl_q[2:1]) == 2'h1 && $past(ctrl_q[5:3]) == 3'h2))
      else $error("icmp field enable wrong");
   a_read_clear: assert property (!reg_rd_in |=> reg_rd_data_out == 32'h0000_0000) else $error("read data outside slot");
endmodule // acl_entry_sva
bind ipv4_acl_entry_matcher acl_entry_sva u_sva (.clk_in, .rst_in, .reg_addr_in, .reg_wr_data_in, .reg_wr_in, .reg_rd_in,
   .reg_rd_data_out, .frame_valid_in, .frame_is_ipv4_in, .frame_proto_in, .frame_ttl_in, .frame_more_frag_in,
   .frame_frag_off_in, .frame_ihl_in, .match_valid_out, .match_hit_out, .icmp_fields_en_out);

// ==== sim/ipv4_acl_entry_matcher_tb_top.sv ====
`timescale 1ns/1ps
module ipv4_acl_entry_matcher_tb_top;
   logic        clk_in, rst_in, reg_wr_in, reg_rd_in;   // clock, reset, strobes
   logic [7:0]  reg_addr_in;                            // register address
   logic [31:0] reg_wr_data_in, reg_rd_data_out, rd_q;  // write, read data, last read
   logic        frame_valid_in, frame_is_ipv4_in, frame_more_frag_in;
   logic [7:0]  frame_proto_in, frame_ttl_in;
   logic [12:0] frame_frag_off_in;
   logic [3:0]  frame_ihl_in;
   logic [31:0] frame_src_addr_in, frame_dst_addr_in;
   logic        match_valid_out, match_hit_out, icmp_fields_en_out, udp_fields_en_out, tcp_fields_en_out;
   logic [31:0] seed = 32'hd0cd_1c62;                    // fixed seed
   logic [31:0] ctrl, sa, sm, da, dm, r, fs, fd;         // config and scratch
   logic [7:0]  fp, ft;
   logic [12:0] fo;
   logic [3:0]  fi;
   logic [2:0]  fe;                                      // expected field enables
   logic        e_cur, e_prev;
   int          error_cnt = 0, n_tests = 0, hits;
   ipv4_acl_entry_matcher DUT (.clk_in, .rst_in, .reg_addr_in, .reg_wr_data_in, .reg_wr_in, .reg_rd_in,
      .reg_rd_data_out, .frame_valid_in, .frame_is_ipv4_in, .frame_proto_in, .frame_ttl_in, .frame_more_frag_in,
      .frame_frag_off_in, .frame_ihl_in, .frame_src_addr_in, .frame_dst_addr_in, .match_valid_out, .match_hit_out,
      .icmp_fields_en_out, .udp_fields_en_out, .tcp_fields_en_out);
   acl_frame_src u_src (.valid_out(frame_valid_in), .ipv4_out(frame_is_ipv4_in), .mf_out(frame_more_frag_in),
      .proto_out(frame_proto_in), .ttl_out(frame_ttl_in), .off_out(frame_frag_off_in), .ihl_out(frame_ihl_in),
      .src_out(frame_src_addr_in), .dst_out(frame_dst_addr_in));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction
   // three-way property condition
   function automatic logic f3(input logic [1:0] m, input logic pr);
      return m == 2'h0 || (m == 2'h1 && !pr) || (m == 2'h2 && pr);
   endfunction
   // address condition; mask zero bits ignored
   function automatic logic fa(input logic [1:0] m, input logic [31:0] c, k, a);
      return m == 2'h0 || (m == 2'h1 && a == c) || (m == 2'h2 && (a & k) == (c & k));
   endfunction
   // protocol condition; unused codes never hit
   function automatic logic fpr(input logic [2:0] m, input logic [7:0] v, p);
      return m == 3'h0 || (m == 3'h1 && p == v) || (m == 3'h2 && p == 8'h01) || (m == 3'h3 && p == 8'h11)
         || (m == 3'h4 && p == 8'h06);
   endfunction
   task automatic chk(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {reg_wr_in, reg_rd_in, reg_addr_in, reg_wr_data_in} <= {1'b1, 1'b0, a, d};
   endtask
   // data taken in the one cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      {reg_wr_in, reg_rd_in, reg_addr_in} <= {1'b0, 1'b1, a};
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 rd_q = reg_rd_data_out;
   endtask
   task automatic close_out;
      if (error_cnt == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // 100 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      {rst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wr_data_in} = {1'b1, 42'h0};
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      // reset values, unmapped and read-only places
      rd(8'h00); chk(rd_q, 32'h0000_0000);
      rd(8'h08); chk(rd_q, 32'hffff_ffff);
      rd(8'h10); chk(rd_q, 32'hffff_ffff);
      wr(8'h1c, 32'hffff_ffff);
      wr(8'h14, 32'hffff_ffff);
      rd(8'h1c); chk(rd_q, 32'h0000_0000);
      rd(8'h14); chk(rd_q[4:1], 4'h0);
      for (int i = 0; i < 300; i++) begin
         r = rnd();
         ctrl = {r[31:16], r[18:9], r[8:6], r[3] ? 2'h1 : (r[5:4] == 2'h3 ? {1'b1, r[0]} : 2'h0), r[2:0] != 3'h0};
         sa = rnd(); da = rnd(); sm = rnd() | rnd(); dm = rnd() | rnd();
         wr(8'h00, ctrl); wr(8'h04, sa); wr(8'h08, sm); wr(8'h0c, da); wr(8'h10, dm); wr(8'h18, 32'h0000_0000);
         hits = 0;
         // four frames back to back, each answer checked one cycle on
         for (int j = 0; j < 5; j++) begin
            @(posedge clk_in);
            reg_wr_in <= 1'b0;
            r = rnd();
            fp = r[2:0] == 3'h0 ? 8'h01 : r[2:0] == 3'h1 ? 8'h06 : r[2:0] == 3'h2 ? 8'h11 : r[2:0] == 3'h3 ?
               ctrl[23:16] : r[15:8];
            ft = r[3] ? 8'h00 : r[23:16];
            fo = (r[6] & r[7]) ? r[28:16] : 13'h0000;
            fi = r[8] ? 4'h5 : r[12:9];
            fs = sa ^ (rnd() & rnd() & rnd() & {32{r[24]}});
            fd = da ^ (rnd() & rnd() & rnd() & {32{r[25]}});
            e_cur = ctrl[0] && (ctrl[2:1] == 2'h0 || (ctrl[2:1] == 2'h1 && (r[13] | r[14]) && fpr(ctrl[5:3],
               ctrl[23:16], fp) && f3(ctrl[7:6], ft != 8'h00) && f3(ctrl[9:8], (r[4] & r[5]) || fo != 13'h0000)
               && f3(ctrl[11:10], fi > 4'h5) && fa(ctrl[13:12], sa, sm, fs) && fa(ctrl[15:14], da, dm, fd)));
            if (j < 4) u_src.put(r[13] | r[14], r[4] & r[5], fp, ft, fo, fi, fs, fd);
            else u_src.idle();
            #1;
            if (j > 0) begin
               chk(match_valid_out, 1'b1);
               chk(match_hit_out, e_prev);
               hits += e_prev;
            end else begin
               chk({match_valid_out, match_hit_out}, 2'h0);
            end
            e_prev = e_cur;
         end
         fe = ctrl[2:1] != 2'h1 ? 3'h0 : {ctrl[5:3] == 3'h4, ctrl[5:3] == 3'h3, ctrl[5:3] == 3'h2};
         chk({tcp_fields_en_out, udp_fields_en_out, icmp_fields_en_out}, fe);
         rd(8'h14); chk(rd_q, {fe, ctrl[2:1] == 2'h1, 1'b0});
         rd(8'h18); chk(rd_q, hits);
         rd(8'h00); chk(rd_q, ctrl);
      end
      close_out();
   end
endmodule // ipv4_acl_entry_matcher_tb_top
